// file: bench/config_host.sv
`timescale 1ns/10ps
`default_nettype none

module config_host
import config_pkg::*;
(
    input  wire logic sdo_w,
    output logic      sclk,
    output logic      sdi,
    output logic      latch_strobe,
    output logic      done,
    output frame_t    rd_word
);
    initial
    begin
        sclk = 1'b0;
        sdi = 1'b0;
        latch_strobe = 1'b0;
        done = 1'b0;
        rd_word = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link clock runs only around reset and inside frames, 160 ns period
    task automatic pulses(input int n);
        repeat (n)
        begin
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
    endtask

    task automatic xfer(input frame_t f);
        for (int i = 15; i >= 0; i--)
        begin
            sdi = f[i];
            #80 sclk = 1'b1;
            #20 rd_word[i] = sdo_w;
            #60 sclk = 1'b0;
        end
        // inverted data line no longer shows the last bit
        sdi = ~sdi;
        #40 latch_strobe = 1'b1;
        #150 latch_strobe = 1'b0;
        #200 done = 1'b1;
        #10 done = 1'b0;
    endtask
endmodule // config_host

`default_nettype wire

// file: bench/serial_config_port_bench.sv
`timescale 1ns/10ps
`default_nettype none

module serial_config_port_bench;
import config_pkg::*;
    localparam reg_data_t IDENT = 9'h13c;  // arbitrary value

    logic        clk;
    logic        sys_rst;
    logic [2:0]  pins;
    logic        bcast;
    logic        sclk;
    logic        sdi;
    logic        latch_strobe;
    logic        done;
    frame_t      rd_word;
    logic        sdo;
    logic        sdo_oe;
    logic        chip_enable;
    logic        rx_buffer_enable;
    logic        divider_core_enable;
    logic        output_buffer_enable;
    div_code_t   divide_ratio;
    wire         sdo_w = sdo_oe ? sdo : 1'b0;
    int          n_errors = 0;
    int          comparisons = 0;
    int          seed;
    logic [23:0] exp_q[$];
    reg_addr_t   ptr;
    logic [3:0]  en;
    div_code_t   div;
    logic        oe;
    logic [31:0] r;

    serial_config_port #(.IDENT_VALUE(IDENT)) u_dut
    (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .sclk                 (sclk),
        .sdi                  (sdi),
        .latch_strobe         (latch_strobe),
        .addr_select_pin0     (pins[0]),
        .addr_select_pin1     (pins[1]),
        .addr_select_pin2     (pins[2]),
        .broadcast_enable     (bcast),
        .sdo                  (sdo),
        .sdo_oe               (sdo_oe),
        .chip_enable          (chip_enable),
        .rx_buffer_enable     (rx_buffer_enable),
        .divider_core_enable  (divider_core_enable),
        .output_buffer_enable (output_buffer_enable),
        .divide_ratio         (divide_ratio)
    );

    config_host u_host
    (
        .sdo_w        (sdo_w),
        .sclk         (sclk),
        .sdi          (sdi),
        .latch_strobe (latch_strobe),
        .done         (done),
        .rd_word      (rd_word)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        comparisons++;
        if (seen !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // note what this frame reads back and leaves behind, then send it
    task automatic frame(input reg_data_t d, input reg_addr_t a, input chip_addr_t c);
        reg_data_t   v;
        logic [15:0] exp_rd;
        logic        acc;
        v = (ptr == 4'h0) ? IDENT : (ptr == 4'h1) ? {5'h0, en} : (ptr == 4'h2) ? {6'h0, div} : 9'h000;
        exp_rd = oe ? {v, 7'h00} : 16'h0000;
        acc = (c == pins) || (bcast && c == 3'h7);
        if (acc)
        begin
            case (a)
                4'h0: ptr = d[3:0];
                4'h1: en = d[3:0];
                4'h2: div = d[2:0];
                default: ;
            endcase
        end
        oe = acc;
        exp_q.push_back({exp_rd, en, div, oe});
        u_host.xfer({d, a, c});
    endtask

    // pointer frame, then the same bits again to shift the register out
    task automatic read(input reg_addr_t a, input chip_addr_t c);
        frame({5'h00, a}, 4'h0, c);
        frame({5'h00, a}, 4'h0, c);
    endtask

    always @(posedge done)
    begin
        if (exp_q.size() == 0)
            check(24'h0, 24'h1);
        else
            check({rd_word, output_buffer_enable, divider_core_enable, rx_buffer_enable, chip_enable,
                   divide_ratio, sdo_oe}, exp_q.pop_front());
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        n_errors++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'h0f4337de;
        sys_rst = 1'b1;
        pins = 3'h3;
        bcast = 1'b0;
        ptr = 4'h0;
        en = 4'hf;
        div = 3'h2;
        oe = 1'b0;
        // one link edge sees reset high; ten clk edges see it high
        fork
            u_host.pulses(1);
            repeat (9) @(posedge clk);
        join
        @(posedge clk) sys_rst <= 1'b0;
        // two link edges carry the reset release through the link side,
        // the second one clears the bit counter before the first frame
        u_host.pulses(2);
        repeat (3) @(posedge clk);
        read(4'h1, 3'h3);
        read(4'h2, 3'h3);
        read(4'h0, 3'h3);
        for (int c = 0; c < 8; c++)
        begin
            frame(9'(c), 4'h2, 3'h3);
            read(4'h2, 3'h3);
        end
        // broadcast refused, then taken
        frame(9'h000, 4'h1, 3'h7);
        @(posedge clk) bcast <= 1'b1;
        repeat (4) @(posedge clk);
        frame(9'h005, 4'h1, 3'h7);
        for (int k = 0; k < 40; k++)
        begin
            r = $random(seed);
            @(posedge clk);
            pins <= r[22:20];
            bcast <= r[19];
            repeat (4) @(posedge clk);
            frame(r[31:23], r[8] ? {2'h0, r[5:4]} : r[13:10], r[16] ? pins : r[2:0]);
        end
        for (int w = 0; w < 1000 && exp_q.size() != 0; w++)
            @(posedge clk);
        if (exp_q.size() != 0)
            n_errors++;
        test_done();
    end
endmodule // serial_config_port_bench

`default_nettype wire

// file: hdl/link_shifter.sv
`timescale 1ns/10ps
`default_nettype none

`include "serial_config_port_regs.svh"

module link_shifter
(
    input  wire logic sclk,
    input  wire logic link_rst,
    input  wire logic sdi,
    output logic      sdo,
    link_if.shifter   lk
);
    import config_pkg::*;

    typedef struct packed
    {
        frame_t     shift;
        logic [3:0] count;
        logic       sdo;
    } shifter_state_t;

    shifter_state_t cur;
    shifter_state_t next_cur;

    always_comb
    begin
        next_cur       = cur;
        // sample on every rising edge, msb first: data, register, chip
        next_cur.shift = {cur.shift[`FRAME_BITS-2:0], sdi};
        // one readback bit per rising edge, wrapping every sixteen
        next_cur.sdo   = lk.readback_word[4'hf - cur.count];
        next_cur.count = cur.count + 4'h1;
    end

    always_ff @(posedge sclk)
    begin
        if (link_rst)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign lk.frame_word = cur.shift;
    assign sdo           = cur.sdo;

    ////////////////////////////////////////////////////////////////////////////////
    property p_shift_in;
        @(posedge sclk) disable iff (link_rst)
        !$past(link_rst, 16) |-> cur.shift[`FRAME_BITS-1] == $past(sdi, 16);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("frame bit lost in shift");

    property p_out_bit;
        @(posedge sclk) disable iff (link_rst)
        !$past(link_rst) |-> sdo == $past(lk.readback_word[4'hf - cur.count]);
    endproperty
    a_out_bit: assert property (p_out_bit) else $error("sdo bit out of order");

endmodule // link_shifter

`default_nettype wire

// file: hdl/serial_config_port.sv
`timescale 1ns/10ps
`default_nettype none

`include "serial_config_port_regs.svh"

module serial_config_port
#(
    parameter config_pkg::reg_data_t IDENT_VALUE = 9'h0a5  // arbitrary value
)
(
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic            sclk,
    input  wire logic            sdi,
    input  wire logic            latch_strobe,
    input  wire logic            addr_select_pin0,
    input  wire logic            addr_select_pin1,
    input  wire logic            addr_select_pin2,
    input  wire logic            broadcast_enable,
    output logic                 sdo,
    output logic                 sdo_oe,
    output logic                 chip_enable,
    output logic                 rx_buffer_enable,
    output logic                 divider_core_enable,
    output logic                 output_buffer_enable,
    output config_pkg::div_code_t divide_ratio
);
    import config_pkg::*;

    if (`FRAME_BITS != (`DATA_MSB - `DATA_LSB + 1) + (`ADDR_MSB - `ADDR_LSB + 1) + (`CHIP_MSB - `CHIP_LSB + 1))
    begin : g_bad_frame
        $error("frame layout does not add up to the frame length");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // crossings

    logic [4:0] pins_sync;
    logic       link_rst;
    logic       strobe_s;
    chip_addr_t own_chip;
    logic       bcast_s;

    sync_bit #(.WIDTH(5)) u_pin_sync
    (
        .clk (clk),
        .rst (sys_rst),
        .d   ({latch_strobe, addr_select_pin2, addr_select_pin1, addr_select_pin0, broadcast_enable}),
        .q   (pins_sync)
    );

    assign strobe_s = pins_sync[4];
    assign own_chip = pins_sync[3:1];
    assign bcast_s  = pins_sync[0];

    // reset reaches the link side only on serial clock edges
    sync_bit #(.WIDTH(1)) u_rst_sync
    (
        .clk (sclk),
        .rst (1'b0),
        .d   (sys_rst),
        .q   (link_rst)
    );

    link_if lk ();

    link_shifter u_shifter
    (
        .sclk     (sclk),
        .link_rst (link_rst),
        .sdi      (sdi),
        .sdo      (sdo),
        .lk       (lk)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic accepts(input chip_addr_t chip, input chip_addr_t own, input logic bcast);
        accepts = (chip == own) || (bcast && (chip == `BCAST_CHIP));
    endfunction

    function automatic reg_data_t read_value(input reg_addr_t ptr, input logic [3:0] en, input div_code_t div);
        case (ptr)
            `REG_ID_PTR:     read_value = IDENT_VALUE;
            `REG_ENABLES:    read_value = {5'h00, en};
            `REG_DIV_SELECT: read_value = {6'h00, div};
            default:         read_value = 9'h000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // register file

    typedef struct packed
    {
        strobe_state_t fsm;
        reg_addr_t     read_ptr;
        logic [3:0]    enables;
        div_code_t     div;
        logic          oe;
        frame_t        readback;
    } port_state_t;

    localparam port_state_t RESET_STATE = '{
        fsm:      ST_IDLE,
        read_ptr: `PTR_RESET,
        enables:  `EN_RESET,
        div:      `DIV_RESET,
        oe:       1'b0,
        readback: {IDENT_VALUE, {`READ_PAD_BITS{1'b0}}}
    };

    port_state_t cur;
    port_state_t next_cur;

    reg_data_t  frame_data;
    reg_addr_t  frame_addr;
    chip_addr_t frame_chip;
    logic       frame_ok;

    // frame word is still while the strobe is high and the serial clock idles
    assign frame_data = lk.frame_word[`DATA_MSB:`DATA_LSB];
    assign frame_addr = lk.frame_word[`ADDR_MSB:`ADDR_LSB];
    assign frame_chip = lk.frame_word[`CHIP_MSB:`CHIP_LSB];
    assign frame_ok   = accepts(frame_chip, own_chip, bcast_s);

    always_comb
    begin
        next_cur = cur;
        case (cur.fsm)
            ST_IDLE:
            begin
                if (strobe_s)
                begin
                    next_cur.fsm = ST_HELD;
                    next_cur.oe  = frame_ok;
                    if (frame_ok)
                    begin
                        case (frame_addr)
                            `REG_ID_PTR:     next_cur.read_ptr = frame_data[`PTR_MSB:0];
                            `REG_ENABLES:    next_cur.enables  = frame_data[`EN_OUT:`EN_CHIP];
                            `REG_DIV_SELECT: next_cur.div      = frame_data[`DIV_MSB:0];
                            default:         next_cur.read_ptr = cur.read_ptr;
                        endcase
                    end
                end
            end
            ST_HELD:
            begin
                if (!strobe_s)
                    next_cur.fsm = ST_IDLE;
            end
            default:
            begin
                next_cur.fsm = ST_IDLE;
            end
        endcase
        // next frame shifts out whatever the pointer names now
        next_cur.readback = {read_value(next_cur.read_ptr, next_cur.enables, next_cur.div),
                             {`READ_PAD_BITS{1'b0}}};
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cur <= RESET_STATE;
        else
            cur <= next_cur;
    end

    assign lk.readback_word       = cur.readback;
    assign sdo_oe                 = cur.oe;
    assign chip_enable            = cur.enables[`EN_CHIP];
    assign rx_buffer_enable       = cur.enables[`EN_RX];
    assign divider_core_enable    = cur.enables[`EN_CORE];
    assign output_buffer_enable   = cur.enables[`EN_OUT];
    assign divide_ratio           = cur.div;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_latch;
        cur.fsm == ST_IDLE && strobe_s;
    endsequence

    sequence s_latch_ok(reg_addr_t a);
        s_latch and (frame_ok && frame_addr == a);
    endsequence

    property p_ptr_write;
        @(posedge clk) disable iff (sys_rst)
        s_latch_ok(`REG_ID_PTR) |=> cur.read_ptr == $past(frame_data[`PTR_MSB:0])
                                    ##1 lk.readback_word[`DATA_MSB:`DATA_LSB] == read_value(cur.read_ptr, cur.enables, cur.div);
    endproperty
    a_ptr_write: assert property (p_ptr_write) else $error("read pointer not written");

    property p_en_write;
        @(posedge clk) disable iff (sys_rst)
        s_latch_ok(`REG_ENABLES) |=> {output_buffer_enable, divider_core_enable, rx_buffer_enable, chip_enable}
                                     == $past(frame_data[3:0]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enables not written");

    property p_div_write;
        @(posedge clk) disable iff (sys_rst)
        s_latch_ok(`REG_DIV_SELECT) |=> divide_ratio == $past(frame_data[`DIV_MSB:0]);
    endproperty
    a_div_write: assert property (p_div_write) else $error("divide select not written");

    property p_reject;
        @(posedge clk) disable iff (sys_rst)
        (s_latch and !frame_ok) |=> $stable(cur.read_ptr) && $stable(cur.enables) && $stable(cur.div) && !sdo_oe;
    endproperty
    a_reject: assert property (p_reject) else $error("rejected frame changed state");

    property p_oe_match;
        @(posedge clk) disable iff (sys_rst)
        s_latch |=> sdo_oe == $past(frame_chip == own_chip || (bcast_s && frame_chip == `BCAST_CHIP));
    endproperty
    a_oe_match: assert property (p_oe_match) else $error("sdo enable disagrees with chip match");

    property p_bcast;
        @(posedge clk) disable iff (sys_rst)
        (s_latch and (bcast_s && frame_chip == 3'h7)) |=> sdo_oe;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast frame refused");

    property p_single_latch;
        @(posedge clk) disable iff (sys_rst)
        // held stays held while the strobe is high, so one pulse commits once
        (s_latch or (cur.fsm == ST_HELD && strobe_s)) |=> cur.fsm == ST_HELD;
    endproperty
    a_single_latch: assert property (p_single_latch) else $error("strobe latched twice");

    property p_id_read;
        @(posedge clk) disable iff (sys_rst)
        (cur.read_ptr == `REG_ID_PTR) ##1 $stable(cur.read_ptr)
            |-> lk.readback_word == {IDENT_VALUE, 7'h00};
    endproperty
    a_id_read: assert property (p_id_read) else $error("identification value wrong");

endmodule // serial_config_port

`default_nettype wire

// file: hdl/sync_bit.sv
`timescale 1ns/10ps
`default_nettype none

module sync_bit
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    if (WIDTH < 1)
    begin : g_bad_width
        $error("sync_bit needs a width of at least one");
    end

    typedef struct packed
    {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t cur;
    sync_state_t next_cur;

    // stage1 feeds stage2 only
    always_comb
    begin
        next_cur        = cur;
        next_cur.stage1 = d;
        next_cur.stage2 = cur.stage1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign q = cur.stage2;

endmodule // sync_bit

`default_nettype wire

// file: inc/config_pkg.sv
package config_pkg;

    typedef enum logic [0:0]
    {
        ST_IDLE = 1'b0,
        ST_HELD = 1'b1
    } strobe_state_t;

    typedef logic [2:0]  div_code_t;
    typedef logic [3:0]  reg_addr_t;
    typedef logic [8:0]  reg_data_t;
    typedef logic [2:0]  chip_addr_t;
    typedef logic [15:0] frame_t;

endpackage

// file: inc/link_if.sv
`timescale 1ns/10ps
`default_nettype none

// frame word leaves the serial clock domain, readback word enters it;
// frame word changes on serial clock edges, readback word only while the serial clock stands still between frames
interface link_if;
    logic [15:0] frame_word;
    logic [15:0] readback_word;

    modport shifter
    (
        output frame_word,
        input  readback_word
    );

    modport regs
    (
        input  frame_word,
        output readback_word
    );
endinterface

`default_nettype wire

// file: inc/serial_config_port_regs.svh
`ifndef SERIAL_CONFIG_PORT_REGS_SVH
`define SERIAL_CONFIG_PORT_REGS_SVH

// register addresses carried in the frame
`define REG_ID_PTR      4'h0
`define REG_ENABLES     4'h1
`define REG_DIV_SELECT  4'h2

// frame layout, first bit shifted ends at the top
`define FRAME_BITS      16
`define DATA_MSB        15
`define DATA_LSB        7
`define ADDR_MSB        6
`define ADDR_LSB        3
`define CHIP_MSB        2
`define CHIP_LSB        0

// field positions inside the 9-bit registers
`define PTR_MSB         3
`define EN_CHIP         0
`define EN_RX           1
`define EN_CORE         2
`define EN_OUT          3
`define DIV_MSB         2

// reset values and the broadcast chip address
`define PTR_RESET       4'h0
`define EN_RESET        4'hf
`define DIV_RESET       3'h2
`define BCAST_CHIP      3'h7

// readback pads the 9 data bits below with zeros
`define READ_PAD_BITS   7

`endif
